// *** design/bit_sync.sv ***
`timescale 1ns/1ps
module bit_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             mclk,
  input  wire logic             resetn,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  if (WIDTH < 1) begin : g_chk
    $error("bit_sync needs WIDTH of at least 1");
  end

  logic [WIDTH-1:0] meta_r;

  // ==========================================================
  // two flops; only the second one is seen by logic
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      meta_r   <= '0;
      sync_out <= '0;
    end else begin
      meta_r   <= async_in;
      sync_out <= meta_r;
    end
  end

endmodule

// *** design/frame_sync_generator.sv ***
// What this block does
// R1 - source codes 0000 to 0011 generate the sync inside, timed from the back-channel frame clock of port 0 to 3.
// R2 - source codes 01xx generate the sync inside, timed from the fixed 25 MHz reference.
// R3 - source codes 1000 to 1111 pass through the sync taken from general-purpose pin 0 to 7.
// R4 - writing one to control bit 3 emits exactly one sync pulse.
// R5 - the one-shot bit clears itself and always reads back as zero.
// R6 - software waits for a one-shot pulse to finish before asking for another.
// R7 - software keeps continuous generation off while using the one-shot pulse.
// R8 - control bit 2 sets the idle level of the sync signal, 0 low and 1 high.
// R9 - with control bit 1 at 0 the high and low phases are timed from separate 16-bit counts.
// R10 - with control bit 1 at 1 a 24-bit count from three bytes times both phases.
// R11 - control bit 0 switches continuous generation on and off.
// R12 - the high phase lasts the programmed high count plus one reference cycle.
// R13 - the high count is split over an upper byte for bits 15:8 and a lower byte for bits 7:0.
// R14 - the low count sits in bytes at 0x1B and 0x1C and its phase lasts the count plus one.
// R15 - with generation off and no one-shot running, the sync holds the idle level.
//
// The Avalon-MM slave port was left to the implementer.
`timescale 1ns/1ps
module frame_sync_generator (
  input  wire logic        mclk,
  input  wire logic        resetn,
  input  wire logic [7:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic [3:0]  bc_frame_clk,
  input  wire logic [7:0]  gpio_in,
  output logic             frame_sync_pulse
);

  // ==========================================================
  // declarations
  fsync_pkg::ctl_t       ctl_r;
  fsync_pkg::counts_t    cnt_cfg_r;
  fsync_pkg::status_t    status;
  fsync_pkg::gen_state_t state_r;
  fsync_pkg::gen_state_t state_nxt;

  logic [3:0]  bc_sync;
  logic [7:0]  gpio_sync;
  logic        ref_tick;

  logic [5:0]  reg_idx;
  logic        addr_ok;
  logic        access;
  logic        wr_en;
  logic        wr_ctl;
  logic [7:0]  wr_byte;
  logic [7:0]  rd_byte;

  logic        shot_req_r;
  logic        shot_drop;
  logic        internal;
  logic        ext_level;
  logic [23:0] len_high;
  logic [23:0] len_low;
  logic [23:0] len_split;
  logic [23:0] phase_r;
  logic [23:0] phase_nxt;
  logic        level_r;
  logic        level_nxt;
  logic        phase_done;

  // ==========================================================
  // pin synchronisers
  bit_sync #(
    .WIDTH (4)
  ) u_bc_sync (
    .mclk     (mclk),
    .resetn   (resetn),
    .async_in (bc_frame_clk),
    .sync_out (bc_sync)
  );

  bit_sync #(
    .WIDTH (8)
  ) u_gpio_sync (
    .mclk     (mclk),
    .resetn   (resetn),
    .async_in (gpio_in),
    .sync_out (gpio_sync)
  );

  // ==========================================================
  // reference tick selection
  ref_tick_gen #(
    .DIV (fsync_pkg::REF_DIV)
  ) u_ref_tick (
    .mclk      (mclk),
    .resetn    (resetn),
    .bc_sync   (bc_sync),
    .sel_port  (ctl_r.sync_source_select[1:0]), // R1
    .use_fixed (ctl_r.sync_source_select[fsync_pkg::SRC_FIXED_BIT]), // R2
    .tick      (ref_tick)
  );

  // ==========================================================
  // bus decode
  // registers are bytes in the low lane of an aligned word
  assign reg_idx = avs_address[7:2];
  assign addr_ok = (avs_address[1:0] == 2'b00);
  assign access  = avs_read | avs_write;
  assign wr_byte = avs_writedata[7:0];

  // a write lands on the edge where waitrequest is seen low
  assign wr_en   = avs_write & ~avs_waitrequest & addr_ok
                 & avs_byteenable[0];
  assign wr_ctl  = wr_en & (reg_idx == fsync_pkg::IDX_CTL);

  // ==========================================================
  // waitrequest: one wait state per access
  // the wait state lets the read mux settle into a register, so
  // readdata comes straight from a flop
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      avs_waitrequest <= 1'b1;
    end else if (access & avs_waitrequest) begin
      avs_waitrequest <= 1'b0;
    end else begin
      avs_waitrequest <= 1'b1;
    end
  end

  // ==========================================================
  // read mux
  always_comb begin
    rd_byte = 8'h00;
    if (addr_ok) begin
      unique case (reg_idx)
        fsync_pkg::IDX_CTL: begin
          rd_byte = ctl_r; // R5
        end
        fsync_pkg::IDX_HIGH_UP: begin
          rd_byte = cnt_cfg_r.high_count_upper_byte;
        end
        fsync_pkg::IDX_HIGH_LO: begin
          rd_byte = cnt_cfg_r.high_count_lower_byte;
        end
        fsync_pkg::IDX_LOW_UP: begin
          rd_byte = cnt_cfg_r.low_count_upper_byte;
        end
        fsync_pkg::IDX_LOW_LO: begin
          rd_byte = cnt_cfg_r.low_count_lower_byte;
        end
        fsync_pkg::IDX_STATUS: begin
          rd_byte = status;
        end
        default: begin
          rd_byte = 8'h00;
        end
      endcase
    end
  end

  // unmapped addresses read as zero
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      avs_readdata <= 32'h0000_0000;
    end else if (avs_read & avs_waitrequest) begin
      avs_readdata <= {24'h00_0000, rd_byte};
    end
  end

  // ==========================================================
  // control register
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      ctl_r <= fsync_pkg::CTL_RESET;
    end else if (wr_ctl) begin
      ctl_r                <= wr_byte;
      ctl_r.one_shot_pulse <= 1'b0; // R5
    end
  end

  // the one-shot bit is never stored, only turned into a request that
  // waits for the next reference tick; starting on a tick keeps the
  // pulse a whole number of ticks long, at the cost of up to one tick
  // of delay, which can be a whole frame clock period on a port source
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      shot_req_r <= 1'b0;
    end else if (wr_ctl) begin
      // a later control write replaces a request not yet served
      shot_req_r <= wr_byte[fsync_pkg::CTL_SHOT_BIT]; // R4
    end else if (shot_drop) begin
      shot_req_r <= 1'b0;
    end
  end

  // served or refused at the first tick; refused at once while the
  // generator runs, a pulse runs or a pin is the source
  assign shot_drop = ref_tick
                   | ~internal
                   | ctl_r.continuous_generation_on
                   | (state_r != fsync_pkg::GEN_IDLE);

  // ==========================================================
  // count registers
  // a new count is picked up at the next phase boundary, so changing it
  // while running leaves the phase in progress at its old length
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      cnt_cfg_r <= {4{fsync_pkg::COUNT_RESET}};
    end else if (wr_en) begin
      unique case (reg_idx)
        fsync_pkg::IDX_HIGH_UP: begin
          cnt_cfg_r.high_count_upper_byte <= wr_byte; // R13
        end
        fsync_pkg::IDX_HIGH_LO: begin
          cnt_cfg_r.high_count_lower_byte <= wr_byte; // R13
        end
        fsync_pkg::IDX_LOW_UP: begin
          cnt_cfg_r.low_count_upper_byte <= wr_byte; // R14
        end
        fsync_pkg::IDX_LOW_LO: begin
          cnt_cfg_r.low_count_lower_byte <= wr_byte; // R14
        end
        default: begin
          cnt_cfg_r <= cnt_cfg_r;
        end
      endcase
    end
  end

  // ==========================================================
  // phase lengths, each one less than the wanted tick count
  assign len_split = {cnt_cfg_r.high_count_lower_byte,
                      cnt_cfg_r.low_count_upper_byte,
                      cnt_cfg_r.low_count_lower_byte}; // R10

  assign len_high = ctl_r.period_split_select ? len_split // R10
                  : {8'h00, cnt_cfg_r.high_count_upper_byte,
                     cnt_cfg_r.high_count_lower_byte}; // R9

  assign len_low  = ctl_r.period_split_select ? len_split // R10
                  : {8'h00, cnt_cfg_r.low_count_upper_byte,
                     cnt_cfg_r.low_count_lower_byte}; // R9

  // ==========================================================
  // source decode
  assign internal  = ~ctl_r.sync_source_select[fsync_pkg::SRC_EXT_BIT];
  assign ext_level = gpio_sync[ctl_r.sync_source_select[2:0]]; // R3

  // a phase ends on the tick that finds the counter at zero,
  // so it lasts the programmed value plus one tick
  assign phase_done = ref_tick & (phase_r == 24'h00_0000); // R12

  // ==========================================================
  // generator state machine
  always_comb begin
    state_nxt = state_r;
    phase_nxt = phase_r;
    level_nxt = level_r;
    unique case (state_r)
      fsync_pkg::GEN_IDLE: begin
        level_nxt = ctl_r.sync_idle_level; // R15
        if (internal & ctl_r.continuous_generation_on) begin
          state_nxt = fsync_pkg::GEN_RUN; // R11
          level_nxt = ctl_r.sync_idle_level; // R8
          phase_nxt = ctl_r.sync_idle_level ? len_high : len_low;
        end else if (internal & shot_req_r & ref_tick) begin
          // the pulse is the level opposite the idle level; its
          // length is counted from the tick that starts it
          state_nxt = fsync_pkg::GEN_SHOT; // R4
          level_nxt = ~ctl_r.sync_idle_level;
          phase_nxt = ctl_r.sync_idle_level ? len_low : len_high;
        end
      end
      fsync_pkg::GEN_RUN: begin
        if (!internal | !ctl_r.continuous_generation_on) begin
          state_nxt = fsync_pkg::GEN_IDLE; // R11
          level_nxt = ctl_r.sync_idle_level; // R15
        end else if (phase_done) begin
          level_nxt = ~level_r;
          phase_nxt = level_r ? len_low : len_high; // R9
        end else if (ref_tick) begin
          phase_nxt = phase_r - 24'h00_0001; // R12
        end
      end
      fsync_pkg::GEN_SHOT: begin
        // a further request while busy is ignored
        if (!internal | phase_done) begin
          state_nxt = fsync_pkg::GEN_IDLE; // R4
          level_nxt = ctl_r.sync_idle_level; // R15
        end else if (ref_tick) begin
          phase_nxt = phase_r - 24'h00_0001; // R12
        end
      end
      default: begin
        state_nxt = fsync_pkg::GEN_IDLE;
        level_nxt = ctl_r.sync_idle_level;
      end
    endcase
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      state_r <= fsync_pkg::GEN_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      phase_r <= 24'h00_0000;
    end else begin
      phase_r <= phase_nxt;
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      level_r <= 1'b0;
    end else begin
      level_r <= level_nxt;
    end
  end

  // ==========================================================
  // output
  // the pin path adds one flop so the output stays registered
  // a pin source skips the generator, so its level reaches the
  // output three clocks after the pin moves
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      frame_sync_pulse <= 1'b0;
    end else if (internal) begin
      frame_sync_pulse <= level_r; // R1
    end else begin
      frame_sync_pulse <= ext_level; // R3
    end
  end

  // ==========================================================
  // status
  assign status.unused    = 5'h00;
  assign status.running   = (state_r == fsync_pkg::GEN_RUN);
  assign status.shot_busy = (state_r == fsync_pkg::GEN_SHOT);
  assign status.level     = frame_sync_pulse;

endmodule

// *** design/fsync_pkg.sv ***
package fsync_pkg;

  // ==========================================================
  // clocking
  localparam int unsigned CLK_HZ  = 50_000_000;
  localparam int unsigned REF_HZ  = 25_000_000;
  localparam int unsigned REF_DIV = CLK_HZ / REF_HZ;

  // ==========================================================
  // register indices; byte address is four times the index
  localparam logic [5:0] IDX_CTL     = 6'h18;
  localparam logic [5:0] IDX_HIGH_UP = 6'h19;
  localparam logic [5:0] IDX_HIGH_LO = 6'h1A;
  localparam logic [5:0] IDX_LOW_UP  = 6'h1B;
  localparam logic [5:0] IDX_LOW_LO  = 6'h1C;
  localparam logic [5:0] IDX_STATUS  = 6'h3F;

  // ==========================================================
  // values after reset
  localparam logic [7:0] CTL_RESET   = 8'h00;
  localparam logic [7:0] COUNT_RESET = 8'h00;

  // ==========================================================
  // field positions: one-shot bit in the control byte, source bits in sync_source_select
  localparam int unsigned CTL_SHOT_BIT  = 3;
  localparam int unsigned SRC_EXT_BIT   = 3;
  localparam int unsigned SRC_FIXED_BIT = 2;

  // ==========================================================
  // carriers
  typedef struct packed {
    logic [3:0] sync_source_select;
    logic       one_shot_pulse;
    logic       sync_idle_level;
    logic       period_split_select;
    logic       continuous_generation_on;
  } ctl_t;

  typedef struct packed {
    logic [7:0] high_count_upper_byte;
    logic [7:0] high_count_lower_byte;
    logic [7:0] low_count_upper_byte;
    logic [7:0] low_count_lower_byte;
  } counts_t;

  typedef struct packed {
    logic [4:0] unused;
    logic       running;
    logic       shot_busy;
    logic       level;
  } status_t;

  typedef enum logic [1:0] {
    GEN_IDLE = 2'b00,
    GEN_RUN  = 2'b01,
    GEN_SHOT = 2'b10
  } gen_state_t;

endpackage

// *** design/ref_tick_gen.sv ***
`timescale 1ns/1ps
module ref_tick_gen #(
  parameter int DIV = fsync_pkg::REF_DIV
) (
  input  wire logic       mclk,
  input  wire logic       resetn,
  input  wire logic [3:0] bc_sync,
  input  wire logic [1:0] sel_port,
  input  wire logic       use_fixed,
  output logic            tick
);

  localparam int CW = (DIV > 1) ? $clog2(DIV) : 1;
  localparam logic [CW-1:0] LAST = CW'(DIV - 1);

  if (DIV < 1) begin : g_chk
    $error("ref_tick_gen needs DIV of at least 1");
  end

  logic [3:0]    bc_prev_r;
  logic [CW-1:0] div_r;
  logic          div_tick;
  logic          port_tick;

  // ==========================================================
  // rising edges of the back-channel frame clocks
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      bc_prev_r <= 4'h0;
    end else begin
      bc_prev_r <= bc_sync;
    end
  end

  assign port_tick = bc_sync[sel_port] & ~bc_prev_r[sel_port];

  // ==========================================================
  // fixed reference: one enable pulse per divided period
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      div_r <= '0;
    end else if (div_r == LAST) begin
      div_r <= '0;
    end else begin
      div_r <= div_r + CW'(1);
    end
  end

  assign div_tick = (div_r == LAST);

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      tick <= 1'b0;
    end else begin
      tick <= use_fixed ? div_tick : port_tick;
    end
  end

endmodule

// *** dv/frame_sync_checker.sv ***
`timescale 1ns/1ps
// ====
// bus handshake and sync output checks
module frame_sync_checker (
  input wire logic        mclk,
  input wire logic        resetn,
  input wire logic [7:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0]  avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  input wire logic [3:0]  bc_frame_clk,
  input wire logic [7:0]  gpio_in,
  input wire logic        frame_sync_pulse
);
  logic [7:0] ctl_r;
  logic [2:0] quiet_r;
  logic       wrote_r;
  logic       wr_ctl;
  assign wr_ctl = avs_write && !avs_waitrequest && avs_address == 8'h60
                  && avs_byteenable[0];
  default clocking @(posedge mclk); endclocking
  default disable iff (!resetn);
  // shadow of the control byte; quiet_r saturates once a write has settled
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      ctl_r   <= 8'h00;
      quiet_r <= 3'h0;
      wrote_r <= 1'h0;
    end else if (wr_ctl) begin
      ctl_r   <= avs_writedata[7:0];
      quiet_r <= 3'h0;
      wrote_r <= 1'h1;
    end else if (quiet_r != 3'h7) begin
      quiet_r <= quiet_r + 3'h1;
    end
  end
  // only the fixed reference bounds how long a shot waits for its tick
  sequence s_shot_req;
    wr_ctl && avs_writedata[3] && avs_writedata[7:6] == 2'b01
    && !avs_writedata[0] && !ctl_r[0] && quiet_r == 3'h7
    && frame_sync_pulse == avs_writedata[2];
  endsequence
  sequence s_shot_out;
    ##[2:5] frame_sync_pulse != ctl_r[2];
  endsequence
  property p_wait_one;
    $fell(avs_waitrequest) |=> avs_waitrequest;
  endproperty
  a_wait_one: assert property (p_wait_one)
    else $error("waitrequest low too long");
  property p_answer;
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
  endproperty
  a_answer: assert property (p_answer)
    else $error("request not answered");
  property p_rdata_hi;
    avs_read && !avs_waitrequest |-> avs_readdata[31:8] == 24'h0;
  endproperty
  a_rdata_hi: assert property (p_rdata_hi)
    else $error("upper read bits set");
  property p_shot_reads0;
    avs_read && !avs_waitrequest && avs_address == 8'h60
    |-> !avs_readdata[3];
  endproperty
  a_shot_reads0: assert property (p_shot_reads0)
    else $error("one-shot bit read back set");
  property p_quiet;
    !wrote_r |-> !frame_sync_pulse;
  endproperty
  a_quiet: assert property (p_quiet)
    else $error("sync moved before configuration");
  property p_idle;
    wr_ctl && avs_writedata[3:0] ==? 4'b0?00 && !avs_writedata[7]
    |-> ##4 frame_sync_pulse == $past(avs_writedata[2], 4);
  endproperty
  a_idle: assert property (p_idle)
    else $error("sync not at idle level");
  property p_shot;
    s_shot_req |-> s_shot_out;
  endproperty
  a_shot: assert property (p_shot)
    else $error("one-shot pulse did not start");
  property p_ext;
    ctl_r[7] && quiet_r == 3'h7
    |-> (($past(gpio_in, 3) >> ctl_r[6:4]) & 8'h01)
        == {7'h00, frame_sync_pulse};
  endproperty
  a_ext: assert property (p_ext)
    else $error("sync does not follow selected pin");
endmodule

bind frame_sync_generator frame_sync_checker u_chk (
  .mclk, .resetn, .avs_address, .avs_read, .avs_write, .avs_writedata,
  .avs_byteenable, .avs_readdata, .avs_waitrequest, .bc_frame_clk,
  .gpio_in, .frame_sync_pulse
);

// *** dv/sync_far_end.sv ***
`timescale 1ns/1ps
// ====
// camera side: free-running frame clocks, pulse timing capture
module sync_far_end (
  input  wire logic        mclk,
  input  wire logic        resetn,
  input  wire logic        frame_sync_pulse,
  output logic      [3:0]  bc_frame_clk,
  output logic      [15:0] hi_len,
  output logic      [15:0] lo_len,
  output logic      [15:0] toggles
);
  logic [3:0][3:0] div_r;
  logic [15:0]     run_r;
  logic            prev_r;
  // port p half period is p+3 cycles, so every port has its own period
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      div_r        <= 16'h0;
      bc_frame_clk <= 4'h0;
    end else begin
      for (int p = 0; p < 4; p++) begin
        if (div_r[p] == 4'(p + 2)) begin
          div_r[p]        <= 4'h0;
          bc_frame_clk[p] <= ~bc_frame_clk[p];
        end else begin
          div_r[p] <= div_r[p] + 4'h1;
        end
      end
    end
  end
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      prev_r  <= 1'h0;
      run_r   <= 16'h1;
      hi_len  <= 16'h0;
      lo_len  <= 16'h0;
      toggles <= 16'h0;
    end else if (frame_sync_pulse != prev_r) begin
      prev_r  <= frame_sync_pulse;
      run_r   <= 16'h1;
      toggles <= toggles + 16'h1;
      if (prev_r) hi_len <= run_r;
      else lo_len <= run_r;
    end else begin
      run_r <= run_r + 16'h1;
    end
  end
endmodule

// *** dv/tb_top.sv ***
`timescale 1ns/1ps
module tb_top;
  localparam int ref_div = fsync_pkg::REF_DIV;
  logic        mclk = 1'h0;
  logic        resetn = 1'h0;
  logic [7:0]  avs_address = 8'h00;
  logic        avs_read = 1'h0;
  logic        avs_write = 1'h0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0]  avs_byteenable = 4'hF;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic [3:0]  bc_frame_clk;
  logic [7:0]  gpio_in = 8'h00;
  logic        frame_sync_pulse;
  logic [15:0] hi_len;
  logic [15:0] lo_len;
  logic [15:0] toggles;
  logic [7:0]  rd;
  int          miscompares = 0;
  int          compares = 0;

  always #10 mclk = ~mclk;

  frame_sync_generator dut (.mclk, .resetn, .avs_address, .avs_read,
    .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata,
    .avs_waitrequest, .bc_frame_clk, .gpio_in, .frame_sync_pulse);
  sync_far_end far (.mclk, .resetn, .frame_sync_pulse, .bc_frame_clk,
    .hi_len, .lo_len, .toggles);

  // ====
  // reporting and bus access
  task automatic complete_run();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d,
                     input logic [3:0] be);
    int n;
    @(posedge mclk);
    avs_address    <= a;
    avs_writedata  <= {24'h0, d};
    avs_byteenable <= be;
    avs_write      <= w;
    avs_read       <= !w;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (avs_waitrequest !== 1'h0 && n < 50);
    chk("bus answer", 1'h0, avs_waitrequest);
    if (avs_waitrequest !== 1'h0) complete_run();
    rd = avs_readdata[7:0];
    avs_write <= 1'h0;
    avs_read  <= 1'h0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    bus(1'h1, a, d, 4'hF);
  endtask
  task automatic rc(input logic [7:0] a, input logic [7:0] e, input string s);
    bus(1'h0, a, 8'h00, 4'hF);
    chk(s, e, rd);
  endtask
  task automatic counts(input logic [7:0] hu, hl, lu, ll);
    wr(8'h64, hu);
    wr(8'h68, hl);
    wr(8'h6C, lu);
    wr(8'h70, ll);
  endtask
  // four toggles leave the last high and low phases fully in new settings
  task automatic widths(input string what, input int eh, input int el);
    int n;
    logic [15:0] t0;
    t0 = toggles;
    n = 0;
    while (toggles < t0 + 16'h4 && n < 2000) begin
      @(posedge mclk);
      n++;
    end
    if (n >= 2000) chk({what, " timeout"}, 1, 0);
    if (n >= 2000) complete_run();
    chk({what, " high"}, eh, hi_len);
    chk({what, " low"}, el, lo_len);
  endtask

  // ====
  // scenarios
  task automatic t_regs();
    for (int i = 0; i < 5; i++) rc(8'h60 + 8'(4 * i), 8'h00, "reset");
    rc(8'h80, 8'h00, "unmapped");
    chk("idle after reset", 1'h0, frame_sync_pulse);
    wr(8'h64, 8'hA5);
    wr(8'h70, 8'h3C);
    bus(1'h1, 8'h64, 8'h11, 4'h0);
    rc(8'h64, 8'hA5, "high upper");
    rc(8'h70, 8'h3C, "low lower");
  endtask
  task automatic t_gen();
    counts(8'h00, 8'h01, 8'h00, 8'h02);
    wr(8'h60, 8'h41);
    widths("src4", ref_div * 2, ref_div * 3);
    wr(8'h60, 8'h71);
    widths("src7", ref_div * 2, ref_div * 3);
    // stop first: a high phase loaded mid-update would outlast the wait
    wr(8'h60, 8'h40);
    counts(8'hFF, 8'h00, 8'h00, 8'h02);
    wr(8'h60, 8'h43);
    widths("fifty", ref_div * 3, ref_div * 3);
    counts(8'h00, 8'h00, 8'h00, 8'h00);
    for (int p = 0; p < 4; p++) begin
      wr(8'h60, {2'h0, 2'(p), 4'h1});
      widths("port", 2 * (p + 3), 2 * (p + 3));
    end
  endtask
  task automatic t_stop();
    logic [15:0] t0;
    wr(8'h60, 8'h00);
    repeat (6) @(posedge mclk);
    t0 = toggles;
    repeat (40) @(posedge mclk);
    chk("stopped level", 1'h0, frame_sync_pulse);
    chk("stopped toggles", t0, toggles);
    wr(8'h60, 8'h04);
    repeat (6) @(posedge mclk);
    chk("idle high", 1'h1, frame_sync_pulse);
    rc(8'hFC, 8'h01, "status idle");
  endtask
  task automatic t_shot();
    logic [15:0] t0;
    counts(8'h00, 8'h02, 8'h00, 8'h01);
    wr(8'h60, 8'h00);
    repeat (10) @(posedge mclk);
    t0 = toggles;
    wr(8'h60, 8'h48);
    repeat (60) @(posedge mclk);
    chk("shot toggles", t0 + 16'h2, toggles);
    chk("shot high", ref_div * 3, hi_len);
    rc(8'h60, 8'h40, "shot bit");
    wr(8'h60, 8'h04);
    repeat (10) @(posedge mclk);
    t0 = toggles;
    wr(8'h60, 8'h4C);
    repeat (60) @(posedge mclk);
    chk("low shot toggles", t0 + 16'h2, toggles);
    chk("low shot", ref_div * 2, lo_len);
  endtask
  task automatic t_ext();
    for (int p = 0; p < 8; p++) begin
      wr(8'h60, {1'h1, 3'(p), 4'h0});
      gpio_in <= ~(8'h01 << p);
      repeat (6) @(posedge mclk);
      chk("pin low", 1'h0, frame_sync_pulse);
      gpio_in <= 8'h01 << p;
      repeat (6) @(posedge mclk);
      chk("pin high", 1'h1, frame_sync_pulse);
    end
  endtask

  initial begin
    repeat (12) @(posedge mclk);
    resetn <= 1'h1;
    t_regs();
    t_gen();
    t_stop();
    t_shot();
    t_ext();
    complete_run();
  end
endmodule
